/* File: src/trsc_pkg.sv */
// Notes on behaviour
// - FIFO window reads give one byte, or two in word mode when two are held; first received byte low.
// - Threshold select picks 32, 16, 4 or 2 accessible bytes; 32 after reset.
// - Pool-full event at threshold without end; end-of-message event loads byte count.
// - Buffer delay readout saturates at all ones above 63 time slots.
// - Frame loss flag follows sync engine; set raises loss event, clear raises recovered.
// - Remote alarm edges raise events; forced in simulation, dropped at quiet steps.
// - Multiframe loss only in F12/F72 formats, with loss and recovered events.
// - Search restart flag toggles whenever a new frame search starts.
// - PRBS status shows synchroniser lock while the PRBS monitor is enabled.
// - Line short of 3 pulses floats outputs for 128 periods, retries every 129 periods, events on change.
// - Line open sets after 32 zeros, clears on a pulse, frozen in tristate mode.
// - Simulation step counter advances on each rising simulation bit, wraps after eight.
// - Each simulation step forces its tabulated indications.
// - Steps 0, 3, 4, 7 clear all pending events in both event registers.
// - Framing error counter counts only in frame sync, saturates, adds two in simulation.
// - Freeze rise stops buffer and resets counter; high-byte read clears freeze; latch mode.
// - B8ZS counts violations not from substitution, plus runs over 7 zeros if enabled.
// - AMI counts all violations, plus runs over 15 zeros if enabled; idle otherwise; simulation every second bit.
package trsc_pkg;
  // **********************************************************
  // Register offsets
  // **********************************************************
  localparam logic [7:0] ADR_FIFO_LO = 8'h00, ADR_FIFO_HI = 8'h01, ADR_DELAY = 8'h49;
  localparam logic [7:0] ADR_STAT0 = 8'h4c, ADR_STAT1 = 8'h4d, ADR_STAT2 = 8'h4e;
  localparam logic [7:0] ADR_FEC_LO = 8'h50, ADR_FEC_HI = 8'h51, ADR_CVC_LO = 8'h52, ADR_CVC_HI = 8'h53;
  localparam logic [7:0] ADR_BCNT_LO = 8'h66, ADR_BCNT_HI = 8'h67;
  localparam logic [7:0] ADR_CTRL0 = 8'h80, ADR_CTRL1 = 8'h81, ADR_FREEZE = 8'h82;
  localparam logic [7:0] ADR_EVT0 = 8'h84, ADR_EVT1 = 8'h85, ADR_CMD = 8'h86;
  // **********************************************************
  // Field positions
  // **********************************************************
  localparam int CT0_THR = 0, CT0_SIM = 2, CT0_CODE = 3, CT0_EXCESS_ZERO_DETECT_EN = 5, CT0_ECM = 6, CT0_WORD = 7;
  localparam int CT1_SSC = 0, CT1_FMT = 2, CT1_PRBS = 4, CT1_ATD = 5, CT1_LTM = 6;
  localparam int S0_LFA = 7, S0_RRA = 6, S0_MULTIFRAME_ALIGN_LOST = 2, S0_SEARCH_RESTART_TOGGLE = 0;
  localparam int S1_PRBS = 4, S1_XLS = 1, S1_XLO = 0, S2_ESC = 5;
  localparam int EV_POOL = 0, EV_EOM = 1, EV_LFA = 2, EV_FAR = 3, EV_RA = 4, EV_RAR = 5, EV_MULTIFRAME_ALIGN_LOST = 6, EV_MULTIFRAME_RECOVERED_IRQ = 7;
  localparam int EV_XL = 0, EV_SEC = 1, CMD_RMC = 0, F_FRM = 0, F_RRA = 1, F_CV = 2;
  // **********************************************************
  // Codes and counts
  // **********************************************************
  localparam logic [1:0] FMT_F4 = 2'b00, FMT_F12 = 2'b01, FMT_F72 = 2'b10, FMT_ESF = 2'b11;
  localparam logic [1:0] CODE_AMI = 2'b10, CODE_B8ZS = 2'b11;
  localparam logic [5:0] FIFO_DEPTH = 6'd32, THR_16 = 6'd16, THR_4 = 6'd4, THR_2 = 6'd2;
  localparam logic [7:0] DELAY_MAX = 8'd63;
  localparam logic [5:0] DELAY_SAT = 6'h3f;
  localparam logic [4:0] ZERO_LIM_B8ZS = 5'd7, ZERO_LIM_AMI = 5'd15, ZRUN_MAX = 5'h1f;
  localparam logic [1:0] SHORT_PULSES = 2'd3;
  localparam logic [6:0] RETRY_LAST = 7'd127;
  localparam logic [5:0] OPEN_ZEROS = 6'd32;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [2:0] ESC_FRM_A = 3'd2, ESC_FRM_B = 3'd6;
  // **********************************************************
  // Types
  // **********************************************************
  typedef enum logic [2:0] {TRSC_SH_RUN = 3'b001, TRSC_SH_FLOAT = 3'b010, TRSC_SH_CHECK = 3'b100} trsc_short_st_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } trsc_bus_t;
  typedef struct packed {
    logic fa_lost;
    logic mfa_lost;
    logic remote_alarm;
    logic search_restart;
    logic prbs_lock;
    logic frame_bit_err;
    logic bpv;
    logic bpv_subst;
    logic rx_bit_valid;
    logic rx_bit;
    logic tx_slot;
    logic tx_mark;
    logic short_sense;
    logic one_sec_tick;
    logic [7:0] elastic_delay;
  } trsc_line_t;
  typedef struct packed {
    logic valid;
    logic eom;
    logic [7:0] data;
  } trsc_hdlc_t;
  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [4:0] wp;
    logic [4:0] rp;
    logic [5:0] cnt;
    logic [5:0] blk;
    logic hold;
    logic ready;
    logic [15:0] msg_len;
    logic [15:0] byte_cnt;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [1:0] frz;
    logic [1:0] frz_prev;
    logic [7:0] evt0;
    logic [1:0] evt1;
    logic frame_align_lost;
    logic remote_alarm_flag;
    logic multiframe_align_lost;
    logic search_restart_toggle;
    logic tx_short_flag;
    logic tx_open_flag;
    logic float;
    trsc_short_st_t sh;
    logic [1:0] sh_cnt;
    logic [6:0] retry;
    logic [5:0] zero_tx;
    logic [2:0] sim_step_count;
    logic sim_prev;
    logic sim_half;
    logic fec_sim_done;
    logic [15:0] fec;
    logic [15:0] fec_buf;
    logic [15:0] cvc;
    logic [15:0] cvc_buf;
    logic [4:0] zrun;
    logic [15:0] rd_data;
  } trsc_state_t;
  // **********************************************************
  // Shared functions
  // **********************************************************
  function automatic logic [5:0] thr_bytes(input logic [1:0] sel);
    case (sel)
      2'b01: return THR_16;
      2'b10: return THR_4;
      2'b11: return THR_2;
      default: return FIFO_DEPTH;
    endcase
  endfunction
  // Counters stop at all ones instead of rolling over
  function automatic logic [15:0] sat_add(input logic [15:0] v, input logic [1:0] n);
    logic [16:0] s;
    s = {1'b0, v} + {15'd0, n};
    return s[16] ? CNT_MAX : s[15:0];
  endfunction
  // Forced indications per step: frame loss, remote alarm, code violations
  function automatic logic [2:0] sim_force(input logic [2:0] sim_step_count);
    case (sim_step_count)
      3'd1: return 3'b110;
      3'd2: return 3'b111;
      3'd5: return 3'b100;
      3'd6: return 3'b011;
      default: return 3'b000;
    endcase
  endfunction
  // Returns {counter, buffer} for one clock of an error counter
  function automatic logic [31:0] ctr_step(input logic [15:0] c, input logic [15:0] b, input logic [1:0] inc,
                                           input logic frz, input logic rise, input logic one_second_latch_mode, input logic tick);
    logic [15:0] nc;
    nc = sat_add(c, inc);
    if (one_second_latch_mode) begin
      return tick ? {sat_add(16'h0000, inc), c} : {nc, b};
    end
    if (rise) begin
      return {16'h0000, b};
    end
    return frz ? {nc, b} : {nc, nc};
  endfunction
endpackage

/* File: src/trsc_status_bank.sv */
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module trsc_status_bank import trsc_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire trsc_bus_t bus,
  input wire trsc_line_t line,
  input wire trsc_hdlc_t hdlc,
  output logic hdlc_ready,
  output logic [15:0] rd_data,
  output logic [1:0] sync_criterion_sel,
  output logic [1:0] frame_format,
  output logic [1:0] line_code_sel,
  output logic excess_zero_detect_en,
  output logic prbs_monitor_en,
  output logic tx_line_float
);
  // **********************************************************
  // State and working signals
  // **********************************************************
  trsc_state_t st_ff;
  trsc_state_t nxt_st;
  logic [5:0] thr;
  logic [5:0] pop;
  logic [2:0] frc;
  logic [2:0] nxt_esc;
  logic [7:0] rb;
  logic [7:0] set0;
  logic [7:0] clr0;
  logic [1:0] set1;
  logic [1:0] clr1;
  logic [1:0] fec_inc;
  logic [1:0] cv_inc;
  logic [1:0] frz_rise;
  logic [4:0] zlim;
  logic [31:0] fec_pair;
  logic [31:0] cvc_pair;
  logic wr_acc;
  logic rd_fifo;
  logic sim_rise;
  logic sim2;
  logic lfa_n;
  logic multiframe_align_lost_n;
  logic rra_n;
  logic cv_on;
  logic b8zs;
  logic bpv_cnt;
  logic excess;
  logic sim_cv;
  logic [7:0] exp_byte;

  always_comb begin
    nxt_st = st_ff;
    rb = 8'h00;
    set0 = 8'h00;
    clr0 = 8'h00;
    set1 = 2'b00;
    clr1 = 2'b00;
    nxt_st.rd_data = 16'h0000;
    thr = thr_bytes(st_ff.ctrl0[CT0_THR +: 2]);
    // ******************************************************
    // Register writes
    // ******************************************************
    if (bus.wr) begin
      case (bus.addr)
        ADR_CTRL0: nxt_st.ctrl0 = bus.wdata;
        ADR_CTRL1: nxt_st.ctrl1 = bus.wdata;
        ADR_FREEZE: nxt_st.frz = bus.wdata[1:0];
        default: ;
      endcase
    end
    // ******************************************************
    // HDLC receive FIFO
    // ******************************************************
    wr_acc = hdlc.valid & st_ff.ready;
    rd_fifo = bus.rd & ((bus.addr == ADR_FIFO_LO) | (bus.addr == ADR_FIFO_HI)) & (st_ff.cnt != 6'd0);
    pop = 6'd0;
    if (rd_fifo) begin
      pop = (st_ff.ctrl0[CT0_WORD] && st_ff.cnt > 6'd1) ? 6'd2 : 6'd1;
    end
    if (wr_acc) begin
      nxt_st.mem[st_ff.wp] = hdlc.data;
      nxt_st.wp = st_ff.wp + 5'd1;
      if (hdlc.eom) begin
        set0[EV_EOM] = 1'b1;
        nxt_st.byte_cnt = st_ff.msg_len + 16'd1;
        nxt_st.msg_len = 16'h0000;
        nxt_st.blk = 6'd0;
        nxt_st.hold = 1'b1;
      end else if (st_ff.blk + 6'd1 == thr) begin
        set0[EV_POOL] = 1'b1;
        nxt_st.msg_len = st_ff.msg_len + 16'd1;
        nxt_st.blk = 6'd0;
        nxt_st.hold = 1'b1;
      end else begin
        nxt_st.msg_len = st_ff.msg_len + 16'd1;
        nxt_st.blk = st_ff.blk + 6'd1;
      end
    end
    nxt_st.rp = st_ff.rp + pop[4:0];
    nxt_st.cnt = st_ff.cnt + {5'd0, wr_acc} - pop;
    // Release drops unread bytes; no byte arrives while held, so wp marks the end
    if (bus.wr && bus.addr == ADR_CMD && bus.wdata[CMD_RMC] && st_ff.hold) begin
      nxt_st.hold = 1'b0;
      nxt_st.rp = st_ff.wp;
      nxt_st.cnt = 6'd0;
    end
    nxt_st.ready = !nxt_st.hold && (nxt_st.cnt < FIFO_DEPTH);
    // ******************************************************
    // Alarm simulation sequencer
    // ******************************************************
    sim_rise = st_ff.ctrl0[CT0_SIM] & ~st_ff.sim_prev;
    nxt_st.sim_prev = st_ff.ctrl0[CT0_SIM];
    nxt_esc = st_ff.sim_step_count + {2'b00, sim_rise};
    nxt_st.sim_step_count = nxt_esc;
    frc = sim_force(st_ff.sim_step_count);
    if (sim_rise && (nxt_esc == 3'd0 || nxt_esc == 3'd3 || nxt_esc == 3'd4 || nxt_esc == 3'd7)) begin
      clr0 = 8'hff;
      clr1 = 2'b11;
    end
    // Framing errors add two once per pass, at step 2 or else step 6
    sim2 = 1'b0;
    if (sim_rise && !line.fa_lost && !st_ff.fec_sim_done && (nxt_esc == ESC_FRM_A || nxt_esc == ESC_FRM_B)) begin
      sim2 = 1'b1;
      nxt_st.fec_sim_done = 1'b1;
    end
    if (sim_rise && nxt_esc == 3'd0) begin
      nxt_st.fec_sim_done = 1'b0;
    end
    // ******************************************************
    // Framer status flags
    // ******************************************************
    lfa_n = line.fa_lost | frc[F_FRM];
    nxt_st.frame_align_lost = lfa_n;
    set0[EV_LFA] = lfa_n & ~st_ff.frame_align_lost;
    set0[EV_FAR] = ~lfa_n & st_ff.frame_align_lost;
    multiframe_align_lost_n = (st_ff.ctrl1[CT1_FMT +: 2] == FMT_F12 || st_ff.ctrl1[CT1_FMT +: 2] == FMT_F72) &
             (line.mfa_lost | frc[F_FRM]);
    nxt_st.multiframe_align_lost = multiframe_align_lost_n;
    set0[EV_MULTIFRAME_ALIGN_LOST] = multiframe_align_lost_n & ~st_ff.multiframe_align_lost;
    set0[EV_MULTIFRAME_RECOVERED_IRQ] = ~multiframe_align_lost_n & st_ff.multiframe_align_lost;
    rra_n = line.remote_alarm | frc[F_RRA];
    nxt_st.remote_alarm_flag = rra_n;
    set0[EV_RA] = rra_n & ~st_ff.remote_alarm_flag;
    set0[EV_RAR] = ~rra_n & st_ff.remote_alarm_flag;
    nxt_st.search_restart_toggle = st_ff.search_restart_toggle ^ line.search_restart;
    set1[EV_SEC] = line.one_sec_tick;
    // ******************************************************
    // Error counters
    // ******************************************************
    fec_inc = {sim2, 1'b0} + {1'b0, line.frame_bit_err & ~st_ff.frame_align_lost};
    b8zs = st_ff.ctrl0[CT0_CODE +: 2] == CODE_B8ZS;
    cv_on = b8zs | (st_ff.ctrl0[CT0_CODE +: 2] == CODE_AMI);
    zlim = b8zs ? ZERO_LIM_B8ZS : ZERO_LIM_AMI;
    bpv_cnt = b8zs ? (line.bpv & ~line.bpv_subst) : line.bpv;
    // A run is counted once, on the zero that first passes the limit
    excess = line.rx_bit_valid & ~line.rx_bit & st_ff.ctrl0[CT0_EXCESS_ZERO_DETECT_EN] & (st_ff.zrun == zlim);
    sim_cv = frc[F_CV] & line.rx_bit_valid & st_ff.sim_half;
    if (line.rx_bit_valid) begin
      nxt_st.zrun = line.rx_bit ? 5'd0 : ((st_ff.zrun == ZRUN_MAX) ? ZRUN_MAX : st_ff.zrun + 5'd1);
      nxt_st.sim_half = frc[F_CV] & ~st_ff.sim_half;
    end
    cv_inc = cv_on ? ({1'b0, bpv_cnt} + {1'b0, excess} + {1'b0, sim_cv}) : 2'd0;
    frz_rise = st_ff.frz & ~st_ff.frz_prev;
    nxt_st.frz_prev = st_ff.frz;
    fec_pair = ctr_step(st_ff.fec, st_ff.fec_buf, fec_inc, st_ff.frz[0], frz_rise[0],
                        st_ff.ctrl0[CT0_ECM], line.one_sec_tick);
    cvc_pair = ctr_step(st_ff.cvc, st_ff.cvc_buf, cv_inc, st_ff.frz[1], frz_rise[1],
                        st_ff.ctrl0[CT0_ECM], line.one_sec_tick);
    nxt_st.fec = fec_pair[31:16];
    nxt_st.fec_buf = fec_pair[15:0];
    nxt_st.cvc = cvc_pair[31:16];
    nxt_st.cvc_buf = cvc_pair[15:0];
    // ******************************************************
    // Transmit line short and open monitor
    // ******************************************************
    if (line.tx_slot) begin
      unique case (st_ff.sh)
        TRSC_SH_RUN: begin
          if (line.short_sense) begin
            nxt_st.sh_cnt = (st_ff.sh_cnt == SHORT_PULSES) ? SHORT_PULSES : st_ff.sh_cnt + 2'd1;
            if (st_ff.sh_cnt + 2'd1 == SHORT_PULSES) begin
              nxt_st.tx_short_flag = 1'b1;
              if (!st_ff.ctrl1[CT1_ATD]) begin
                nxt_st.float = 1'b1;
                nxt_st.retry = 7'd0;
                nxt_st.sh = TRSC_SH_FLOAT;
              end
            end
          end else begin
            nxt_st.sh_cnt = 2'd0;
            nxt_st.tx_short_flag = 1'b0;
          end
        end
        TRSC_SH_FLOAT: begin
          nxt_st.retry = st_ff.retry + 7'd1;
          if (st_ff.retry == RETRY_LAST) begin
            nxt_st.float = 1'b0;
            nxt_st.sh = TRSC_SH_CHECK;
          end
        end
        TRSC_SH_CHECK: begin
          if (line.short_sense) begin
            nxt_st.float = 1'b1;
            nxt_st.retry = 7'd0;
            nxt_st.sh = TRSC_SH_FLOAT;
          end else begin
            nxt_st.tx_short_flag = 1'b0;
            nxt_st.sh_cnt = 2'd0;
            nxt_st.sh = TRSC_SH_RUN;
          end
        end
        default: begin
          nxt_st.float = 1'b0;
          nxt_st.sh = TRSC_SH_RUN;
        end
      endcase
      if (line.tx_mark) begin
        nxt_st.zero_tx = 6'd0;
        nxt_st.tx_open_flag = 1'b0;
      end else if (st_ff.zero_tx != OPEN_ZEROS) begin
        nxt_st.zero_tx = st_ff.zero_tx + 6'd1;
        nxt_st.tx_open_flag = (st_ff.zero_tx + 6'd1 == OPEN_ZEROS);
      end
    end
    // Tristate mode holds both flags so the host sees a stable picture
    if (st_ff.ctrl1[CT1_LTM]) begin
      nxt_st.tx_short_flag = st_ff.tx_short_flag;
      nxt_st.tx_open_flag = st_ff.tx_open_flag;
    end
    set1[EV_XL] = (nxt_st.tx_short_flag ^ st_ff.tx_short_flag) | (nxt_st.tx_open_flag & ~st_ff.tx_open_flag);
    // ******************************************************
    // Register reads, one cycle later, zero otherwise
    // ******************************************************
    if (bus.rd) begin
      case (bus.addr)
        ADR_FIFO_LO, ADR_FIFO_HI: begin
          if (rd_fifo) begin
            nxt_st.rd_data[7:0] = st_ff.mem[st_ff.rp];
            if (pop == 6'd2) begin
              nxt_st.rd_data[15:8] = st_ff.mem[st_ff.rp + 5'd1];
            end
          end
        end
        ADR_DELAY: rb[5:0] = (line.elastic_delay > DELAY_MAX) ? DELAY_SAT : line.elastic_delay[5:0];
        ADR_STAT0: begin
          rb[S0_LFA] = st_ff.frame_align_lost;
          rb[S0_RRA] = st_ff.remote_alarm_flag;
          rb[S0_MULTIFRAME_ALIGN_LOST] = st_ff.multiframe_align_lost;
          rb[S0_SEARCH_RESTART_TOGGLE] = st_ff.search_restart_toggle;
        end
        ADR_STAT1: begin
          rb[S1_PRBS] = st_ff.ctrl1[CT1_PRBS] & line.prbs_lock;
          rb[S1_XLS] = st_ff.tx_short_flag;
          rb[S1_XLO] = st_ff.tx_open_flag;
        end
        ADR_STAT2: rb[S2_ESC +: 3] = st_ff.sim_step_count;
        ADR_FEC_LO: rb = st_ff.fec_buf[7:0];
        ADR_FEC_HI: begin
          rb = st_ff.fec_buf[15:8];
          nxt_st.frz[0] = 1'b0;
        end
        ADR_CVC_LO: rb = st_ff.cvc_buf[7:0];
        ADR_CVC_HI: begin
          rb = st_ff.cvc_buf[15:8];
          nxt_st.frz[1] = 1'b0;
        end
        ADR_BCNT_LO: rb = st_ff.byte_cnt[7:0];
        ADR_BCNT_HI: rb = st_ff.byte_cnt[15:8];
        ADR_CTRL0: rb = st_ff.ctrl0;
        ADR_CTRL1: rb = st_ff.ctrl1;
        ADR_FREEZE: rb[1:0] = st_ff.frz;
        ADR_EVT0: begin
          rb = st_ff.evt0;
          clr0 = 8'hff;
        end
        ADR_EVT1: begin
          rb[1:0] = st_ff.evt1;
          clr1 = 2'b11;
        end
        default: ;
      endcase
      if (!rd_fifo) begin
        nxt_st.rd_data = {8'h00, rb};
      end
    end
    // Sticky events: a set in the clearing cycle survives
    nxt_st.evt0 = (st_ff.evt0 & ~clr0) | set0;
    nxt_st.evt1 = (st_ff.evt1 & ~clr1) | set1;
  end

  // State register; only constants under reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.sh <= TRSC_SH_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register
  assign hdlc_ready = st_ff.ready;
  assign rd_data = st_ff.rd_data;
  assign sync_criterion_sel = st_ff.ctrl1[CT1_SSC +: 2];
  assign frame_format = st_ff.ctrl1[CT1_FMT +: 2];
  assign line_code_sel = st_ff.ctrl0[CT0_CODE +: 2];
  assign excess_zero_detect_en = st_ff.ctrl0[CT0_EXCESS_ZERO_DETECT_EN];
  assign prbs_monitor_en = st_ff.ctrl1[CT1_PRBS];
  assign tx_line_float = st_ff.float;

  // **********************************************************
  // Assertions
  // **********************************************************
  assign exp_byte = st_ff.mem[st_ff.rp];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_FIFO_LSB_FIRST: assert property (
    bus.rd && bus.addr == ADR_FIFO_LO && st_ff.cnt != 6'd0 && !st_ff.ctrl0[CT0_WORD]
    |=> rd_data == {8'h00, $past(exp_byte)}) else $error("fifo byte out of order");
  AST_POOL_FULL: assert property (
    wr_acc && !hdlc.eom && st_ff.blk + 6'd1 == thr
    |=> st_ff.evt0[EV_POOL] && !hdlc_ready) else $error("pool full not raised at threshold");
  AST_DELAY_SAT: assert property (
    bus.rd && bus.addr == ADR_DELAY && line.elastic_delay > DELAY_MAX
    |=> rd_data == {10'h000, DELAY_SAT}) else $error("delay not saturated");
  AST_FAR_ON_CLEAR: assert property (
    $fell(st_ff.frame_align_lost) |-> st_ff.evt0[EV_FAR]) else $error("recovery event missing");
  AST_RA_EDGE: assert property (
    $rose(st_ff.remote_alarm_flag) |-> st_ff.evt0[EV_RA]) else $error("remote alarm event missing");
  AST_MULTIFRAME_ALIGN_LOST_FORMAT: assert property (
    st_ff.multiframe_align_lost |-> $past(frame_format) == FMT_F12 || $past(frame_format) == FMT_F72)
    else $error("multiframe loss outside F12/F72");
  AST_SEARCH_RESTART_TOGGLE_TOGGLE: assert property (
    line.search_restart |=> st_ff.search_restart_toggle != $past(st_ff.search_restart_toggle)) else $error("search flag did not toggle");
  AST_PRBS_STATUS: assert property (
    bus.rd && bus.addr == ADR_STAT1 |=> rd_data[S1_PRBS] == $past(prbs_monitor_en && line.prbs_lock))
    else $error("prbs status wrong");
  AST_SHORT_FLOAT: assert property (
    $rose(st_ff.tx_short_flag) && !st_ff.ctrl1[CT1_ATD] |-> tx_line_float && st_ff.evt1[EV_XL])
    else $error("short did not float outputs");
  AST_OPEN_COUNT: assert property (
    $rose(st_ff.tx_open_flag) |-> st_ff.zero_tx == OPEN_ZEROS && st_ff.evt1[EV_XL]) else $error("open flag early");
  AST_SIM_STEP: assert property (
    sim_rise |=> st_ff.sim_step_count == $past(st_ff.sim_step_count) + 3'd1) else $error("simulation step not advanced");
  AST_SIM_FORCE: assert property (
    st_ff.sim_step_count == 3'd2 && $past(st_ff.sim_step_count) == 3'd2 |-> st_ff.frame_align_lost && st_ff.remote_alarm_flag) else $error("step 2 not forced");
  AST_FEC_SAT: assert property (
    st_ff.fec == CNT_MAX && !line.one_sec_tick && !(st_ff.frz[0] && !st_ff.frz_prev[0])
    |=> st_ff.fec == CNT_MAX) else $error("framing counter rolled over");
  AST_FREEZE_CLEAR: assert property (
    bus.rd && bus.addr == ADR_FEC_HI |=> !st_ff.frz[0]) else $error("freeze not cleared by high read");

  COV_POOL_FULL: cover property (wr_acc && !hdlc.eom && st_ff.blk + 6'd1 == thr);
  COV_EOM: cover property (wr_acc && hdlc.eom ##1 bus.wr && bus.addr == ADR_CMD);
  COV_SIM_STEP2: cover property (sim_rise && nxt_esc == ESC_FRM_A);
  COV_SHORT: cover property ($rose(st_ff.tx_short_flag));
endmodule
`default_nettype wire

/* File: tb/trsc_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Line and remote terminal side
// ****************************************
module trsc_line_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic send_zeros,
  output logic tx_slot,
  output logic tx_mark,
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic [1:0] ph_ff;
  // Free running phase, a transmit slot every fourth clock
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_ff <= 2'h0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
    end
  end
  // Received bits alternate, so no zero run ever looks excessive
  assign tx_slot = ph_ff == 2'h3;
  assign tx_mark = tx_slot & !send_zeros;
  assign rx_bit_valid = ph_ff[0];
  assign rx_bit = ph_ff[1];
endmodule
`default_nettype wire

/* File: tb/trsc_status_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module trsc_status_bank_bench import trsc_pkg::*;;
  logic mclk = 1'b0, rst_b = 1'b0, fa = 1'b0, ra = 1'b0, fbe = 1'b0, bpv = 1'b0, zeros = 1'b0, sht = 1'b0;
  logic txs, txm, rxv, rxb, rdy, flt;
  logic [7:0] ctl;
  logic [7:0] dly = 8'h00;
  logic [15:0] rdat;
  logic [7:0] rows [4][2] = '{'{8'h0a, 8'h0a}, '{8'h3f, 8'h3f}, '{8'h40, 8'h3f}, '{8'hc8, 8'h3f}};
  int fails = 0, total_checks = 0;
  trsc_bus_t bus = '0;
  trsc_hdlc_t hdlc = '0;
  trsc_line_t line;
  // ****************************************
  // Design, line side and clock
  // ****************************************
  assign line = {fa, fa, ra, 1'b0, 1'b0, fbe, bpv, 1'b0, rxv, rxb, txs, txm, sht, 1'b0, dly};
  trsc_line_model i_line (.mclk(mclk), .rst_b(rst_b), .send_zeros(zeros), .tx_slot(txs), .tx_mark(txm),
    .rx_bit_valid(rxv), .rx_bit(rxb));
  trsc_status_bank i_dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .line(line), .hdlc(hdlc), .hdlc_ready(rdy),
    .rd_data(rdat), .sync_criterion_sel(ctl[7:6]), .frame_format(ctl[5:4]), .line_code_sel(ctl[3:2]),
    .excess_zero_detect_en(ctl[1]), .prbs_monitor_en(ctl[0]), .tx_line_float(flt));
  initial forever #25 mclk = ~mclk;
  // Watchdog, well beyond the fewer than one thousand clocks the tests need
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask
  // Read data are looked at in the one cycle where they stand
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 chk(nm, exp, rdat);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    chk("ready in reset", 16'h0000, {15'h0, rdy});
    rst_b <= 1'b1;
    // Delay readout rows, saturating above 63 slots
    foreach (rows[i]) begin
      @(posedge mclk);
      dly <= rows[i][0];
      repeat (2) @(posedge mclk);
      rd(ADR_DELAY, {8'h00, rows[i][1]}, "delay");
    end
    rd(8'h7f, 16'h0000, "unmapped");
    $display("test delay done");
    // Two byte block, then release by command
    wr(ADR_CTRL0, 8'h03);
    @(posedge mclk);
    hdlc <= '{valid: 1'b1, eom: 1'b0, data: 8'ha5};
    @(posedge mclk);
    hdlc.data <= 8'h3c;
    @(posedge mclk);
    hdlc <= '0;
    repeat (2) @(posedge mclk);
    chk("ready held", 16'h0000, {15'h0, rdy});
    rd(ADR_EVT0, 16'h0001, "pool event");
    rd(ADR_FIFO_LO, 16'h00a5, "fifo first");
    rd(ADR_FIFO_HI, 16'h003c, "fifo second");
    rd(ADR_FIFO_LO, 16'h0000, "fifo empty");
    wr(ADR_CMD, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk("ready released", 16'h0001, {15'h0, rdy});
    $display("test fifo done");
    // Frame loss and remote alarm, both edges
    @(posedge mclk);
    {fa, ra} <= 2'b11;
    rd(ADR_STAT0, 16'h00c0, "stat0 set");
    rd(ADR_EVT0, 16'h0014, "loss events");
    @(posedge mclk);
    {fa, ra} <= 2'b00;
    rd(ADR_STAT0, 16'h0000, "stat0 clear");
    rd(ADR_EVT0, 16'h0028, "recover events");
    $display("test alarms done");
    // Framing errors, freeze holds the buffer, high read thaws it
    @(posedge mclk);
    fbe <= 1'b1;
    repeat (3) @(posedge mclk);
    fbe <= 1'b0;
    rd(ADR_FEC_LO, 16'h0003, "fec");
    wr(ADR_FREEZE, 8'h01);
    @(posedge mclk);
    fbe <= 1'b1;
    @(posedge mclk);
    fbe <= 1'b0;
    rd(ADR_FEC_LO, 16'h0003, "fec frozen");
    rd(ADR_FEC_HI, 16'h0000, "fec high");
    rd(ADR_FEC_LO, 16'h0001, "fec thawed");
    // AMI: one violation counted
    wr(ADR_CTRL0, 8'h13);
    @(posedge mclk);
    bpv <= 1'b1;
    @(posedge mclk);
    bpv <= 1'b0;
    rd(ADR_CVC_LO, 16'h0001, "cvc");
    $display("test counters done");
    // Open line after 32 zero slots, cleared by a pulse
    @(posedge mclk);
    zeros <= 1'b1;
    repeat (160) @(posedge mclk);
    rd(ADR_STAT1, 16'h0001, "open set");
    @(posedge mclk);
    zeros <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(ADR_STAT1, 16'h0000, "open clear");
    // Short over a few slots floats the outputs until the retry span ends
    @(posedge mclk);
    sht <= 1'b1;
    repeat (16) @(posedge mclk);
    #1 chk("float", 16'h0001, {15'h0, flt});
    rd(ADR_STAT1, 16'h0002, "short set");
    @(posedge mclk);
    sht <= 1'b0;
    repeat (540) @(posedge mclk);
    #1 chk("float off", 16'h0000, {15'h0, flt});
    rd(ADR_STAT1, 16'h0000, "short clear");
    rd(ADR_EVT1, 16'h0001, "line change");
    // Simulation steps; spacing is short, only step and the forcing at step one and after the wrap to step zero are looked at
    wr(ADR_CTRL0, 8'h17);
    rd(ADR_STAT2, 16'h0020, "step one");
    rd(ADR_STAT0, 16'h0040, "step one alarm");
    repeat (7) begin
      wr(ADR_CTRL0, 8'h13);
      wr(ADR_CTRL0, 8'h17);
    end
    rd(ADR_STAT2, 16'h0000, "step wrap");
    rd(ADR_STAT0, 16'h0000, "step quiet");
    $display("test simulation done");
    // Control copies on the outputs
    wr(ADR_CTRL1, 8'h1f);
    #1 chk("controls", 16'h00f9, {8'h00, ctl});
    complete_run();
  end
endmodule
`default_nettype wire
